// >>> remap_regs.svh
/*
  offsets, field positions, reset values and fixed counts of the remap
  table and page queue pointer registers.
  assumes: included by bare name wherever the register map is needed.
*/
`ifndef REMAP_REGS_SVH
`define REMAP_REGS_SVH

// ************************************************************
// byte offsets
// ************************************************************
`define OFF_TABLE_BASE 8'hb8
`define OFF_QUEUE_HEAD 8'hc0
`define OFF_QUEUE_TAIL 8'hc8

// ************************************************************
// field positions
// ************************************************************
`define POS_BASE_LO 12
`define POS_EXT_EN 11
`define POS_SIZE_HI 3
`define POS_PTR_HI 18
`define POS_PTR_LO 5

// ************************************************************
// reset values and counts
// ************************************************************
`define RST_BASE 52'h0
`define RST_EXT_EN 1'b0
`define RST_SIZE 4'h0
`define RST_PTR 14'h0
`define QUEUE_PAGE_SHIFT 7

`endif

// >>> remap_pkg.sv
/*
  types shared by the remap register bank and its tail tracker.
  assumes: compiled before every module that imports it.
*/
package remap_pkg;

  typedef logic [13:0] ptr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [63:0] wdata;
    logic wr;
    logic rd;
  } reg_bus_s;

  typedef struct packed {
    logic [51:0] base;
    logic ext_en;
    logic [3:0] size;
  } table_cfg_s;

endpackage

// >>> page_tail_ctrl.sv
/*
  page request queue tail pointer and pending flag.
  assumes: head, size and capability come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "remap_regs.svh"

module page_tail_ctrl
  import remap_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic capable_i,
  input wire logic [2:0] queue_size_i,
  input wire ptr_t head_i,
  input wire logic sw_wr_i,
  input wire ptr_t sw_tail_i,
  input wire logic req_valid_i,
  input wire logic pending_clear_i,
  output logic req_ready_o,
  output logic full_o,
  output ptr_t tail_o,
  output logic pending_o
);

  // index mask for a queue of 2^(x+7) entries
  function automatic ptr_t queue_mask(input logic [2:0] x);
    logic [14:0] m;
    m = (15'h1 << ({1'b0, x} + 4'(`QUEUE_PAGE_SHIFT))) - 15'h1; // RULE13
    return m[13:0];
  endfunction

  ptr_t next_tail;
  logic accept;

  assign next_tail = (tail_o + 14'h1) & queue_mask(queue_size_i); // RULE15
  assign full_o = (next_tail == head_i); // RULE15
  // a software write to the tail owns that cycle, so no entry is taken
  assign req_ready_o = capable_i && !full_o && !sw_wr_i; // RULE12
  assign accept = req_valid_i && req_ready_o;

  // ************************************************************
  // tail pointer
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tail_o <= `RST_PTR; // RULE16
    end else if (sw_wr_i && capable_i) begin
      tail_o <= sw_tail_i & queue_mask(queue_size_i);
    end else if (accept) begin
      tail_o <= next_tail; // RULE11
    end
  end

  // ************************************************************
  // pending flag, set wins over clear
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pending_o <= 1'b0;
    end else if (accept) begin
      pending_o <= 1'b1; // RULE14
    end else if (pending_clear_i) begin
      pending_o <= 1'b0;
    end
  end

endmodule

// >>> remap_ptr_regs.sv
/*
  remap table base register, page queue head and tail registers, the
  latched table pointer in use, destination id decoding and the page
  request write slot.
  assumes: capability, size and strobe inputs come from logic on the
  same clock; the bus master keeps strobes one cycle long.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "remap_regs.svh"

// Functional notes
// RULE1 - software aligns table base to 4 KB; low twelve bits are zero.
// RULE2 - base bits at and above host address width are dropped.
// RULE3 - written table settings take effect only on the latch command.
// RULE4 - legacy format uses destination bits 15:8 only, rest ignored.
// RULE5 - wide format uses the full 32-bit destination identifier.
// RULE6 - without wide capability the format enable reads zero, ignores writes.
// RULE7 - software keeps format enable stable while remapping is active.
// RULE8 - table size field x gives 2^(x+1) entries.
// RULE9 - without remap capability the base register reads zero, drops writes.
// RULE10 - software keeps head as offset of next entry to consume.
// RULE11 - hardware keeps tail as next write offset, advancing per entry.
// RULE12 - without page request capability head and tail read zero, drop writes.
// RULE13 - queue size x gives 2^(x+7) entries of 32 bytes.
// RULE14 - every added page request entry sets the pending flag.
// RULE15 - tail wraps modulo queue size; full when next tail meets head.
// RULE16 - all fields reset to zero, reserved bits read zero.
module remap_ptr_regs
  import remap_pkg::*;
#(
  parameter int HOST_ADDR_WIDTH = 48
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire reg_bus_s reg_bus_i,
  output logic [63:0] reg_rdata_o,
  input wire logic intr_remap_capable_i,
  input wire logic ext_dest_format_capable_i,
  input wire logic page_req_capable_i,
  input wire logic latch_table_ptr_i,
  input wire logic [2:0] queue_size_field_i,
  input wire logic dest_valid_i,
  input wire logic [31:0] dest_id_i,
  input wire logic page_req_valid_i,
  input wire logic pending_clear_i,
  output table_cfg_s active_cfg_o,
  output logic [16:0] table_entries_o,
  output logic dest_valid_o,
  output logic [31:0] dest_id_o,
  output logic page_req_ready_o,
  output logic queue_full_o,
  output logic [18:0] write_offset_o,
  output logic pending_page_req_flag_o
);

  // ************************************************************
  // helpers
  // ************************************************************
  // keeps only base bits below the host address width
  function automatic logic [51:0] haw_mask();
    logic [51:0] m;
    m = 52'h0;
    for (int i = 0; i < 52; i++) begin
      m[i] = ((i + `POS_BASE_LO) < HOST_ADDR_WIDTH);
    end
    return m;
  endfunction

  function automatic logic [16:0] entry_count(input logic [3:0] x);
    return 17'h1 << ({1'b0, x} + 5'h1);
  endfunction

  // entry index mask for a page queue of 2^(x+7) entries
  function automatic ptr_t queue_index_mask(input logic [2:0] x);
    return 14'((15'h1 << ({1'b0, x} + 4'(`QUEUE_PAGE_SHIFT))) - 15'h1);
  endfunction

  function automatic logic hit(input reg_bus_s b, input logic [7:0] off);
    return b.addr == off;
  endfunction

  // ************************************************************
  // stored table settings
  // ************************************************************
  table_cfg_s stored;
  ptr_t head;
  ptr_t tail;
  logic wr_table;
  logic wr_head;
  logic wr_tail;

  assign wr_table = reg_bus_i.wr && hit(reg_bus_i, `OFF_TABLE_BASE);
  assign wr_head = reg_bus_i.wr && hit(reg_bus_i, `OFF_QUEUE_HEAD);
  assign wr_tail = reg_bus_i.wr && hit(reg_bus_i, `OFF_QUEUE_TAIL);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      stored.base <= `RST_BASE; // RULE16
      stored.ext_en <= `RST_EXT_EN;
      stored.size <= `RST_SIZE;
    end else if (wr_table && intr_remap_capable_i) begin // RULE9
      // low twelve address bits are never stored
      stored.base <= reg_bus_i.wdata[63:`POS_BASE_LO] & haw_mask(); // RULE2
      stored.ext_en <= reg_bus_i.wdata[`POS_EXT_EN] && ext_dest_format_capable_i; // RULE6
      stored.size <= reg_bus_i.wdata[`POS_SIZE_HI:0];
    end
  end

  // ************************************************************
  // settings in use
  // ************************************************************
  // software may rewrite the stored copy freely; lookups see only this one
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      active_cfg_o <= '0;
    end else if (latch_table_ptr_i && intr_remap_capable_i) begin
      active_cfg_o <= stored; // RULE3
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      table_entries_o <= entry_count(`RST_SIZE);
    end else if (latch_table_ptr_i && intr_remap_capable_i) begin
      table_entries_o <= entry_count(stored.size); // RULE8
    end
  end

  // ************************************************************
  // destination id decoding
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dest_valid_o <= 1'b0;
      dest_id_o <= 32'h0;
    end else begin
      dest_valid_o <= dest_valid_i;
      if (active_cfg_o.ext_en) begin
        dest_id_o <= dest_id_i; // RULE5
      end else begin
        dest_id_o <= {24'h0, dest_id_i[15:8]}; // RULE4
      end
    end
  end

  // ************************************************************
  // page queue head
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      head <= `RST_PTR;
    end else if (wr_head && page_req_capable_i) begin // RULE12
      head <= reg_bus_i.wdata[`POS_PTR_HI:`POS_PTR_LO];
    end
  end

  page_tail_ctrl u_tail (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .capable_i(page_req_capable_i),
    .queue_size_i(queue_size_field_i), // RULE13
    .head_i(head),
    .sw_wr_i(wr_tail),
    .sw_tail_i(reg_bus_i.wdata[`POS_PTR_HI:`POS_PTR_LO]),
    .req_valid_i(page_req_valid_i),
    .pending_clear_i(pending_clear_i),
    .req_ready_o(page_req_ready_o),
    .full_o(queue_full_o),
    .tail_o(tail),
    .pending_o(pending_page_req_flag_o)
  );

  assign write_offset_o = {tail, 5'h0}; // RULE11

  // ************************************************************
  // read data
  // ************************************************************
  // unmapped offsets answer zero; reserved bits are filled with zero
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 64'h0;
    end else if (!reg_bus_i.rd) begin
      reg_rdata_o <= 64'h0;
    end else if (hit(reg_bus_i, `OFF_TABLE_BASE) && intr_remap_capable_i) begin
      reg_rdata_o <= {stored.base, stored.ext_en, 7'h0, stored.size}; // RULE16
    end else if (hit(reg_bus_i, `OFF_QUEUE_HEAD) && page_req_capable_i) begin
      reg_rdata_o <= {45'h0, head, 5'h0};
    end else if (hit(reg_bus_i, `OFF_QUEUE_TAIL) && page_req_capable_i) begin
      reg_rdata_o <= {45'h0, tail, 5'h0};
    end else begin
      reg_rdata_o <= 64'h0; // RULE9 RULE12
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  logic accept;
  assign accept = page_req_valid_i && page_req_ready_o;

  chk_unmapped_zero: assert property ( // RULE16
    reg_bus_i.rd && !hit(reg_bus_i, `OFF_TABLE_BASE)
    && !hit(reg_bus_i, `OFF_QUEUE_HEAD) && !hit(reg_bus_i, `OFF_QUEUE_TAIL)
    |=> reg_rdata_o == 64'h0)
    else $error("unmapped read not zero");

  chk_table_rsvd_rd: assert property ( // RULE9
    reg_bus_i.rd && hit(reg_bus_i, `OFF_TABLE_BASE) && !intr_remap_capable_i
    |=> reg_rdata_o == 64'h0)
    else $error("table base visible without capability");

  chk_table_readback: assert property ( // RULE2
    wr_table && intr_remap_capable_i ##1
    reg_bus_i.rd && hit(reg_bus_i, `OFF_TABLE_BASE) && intr_remap_capable_i
    && !wr_table
    |=> reg_rdata_o[63:12] == ($past(reg_bus_i.wdata[63:12], 2) & haw_mask())
    && reg_rdata_o[10:4] == 7'h0)
    else $error("table base readback wrong");

  chk_ext_rsvd: assert property ( // RULE6
    !ext_dest_format_capable_i && wr_table && intr_remap_capable_i |=> !stored.ext_en)
    else $error("format enable stored without capability");

  chk_latch_hold: assert property ( // RULE3
    !latch_table_ptr_i |=> $stable(active_cfg_o))
    else $error("settings in use changed without latch");

  chk_latch_take: assert property ( // RULE3
    latch_table_ptr_i && intr_remap_capable_i
    |=> active_cfg_o == $past(stored))
    else $error("latch did not take stored settings");

  chk_entry_count: assert property ( // RULE8
    latch_table_ptr_i && intr_remap_capable_i
    |=> table_entries_o == (17'h1 << (active_cfg_o.size + 5'h1)))
    else $error("table entry count wrong");

  chk_legacy_dest: assert property ( // RULE4
    dest_valid_i && !active_cfg_o.ext_en && !latch_table_ptr_i
    |=> dest_valid_o && dest_id_o == {24'h0, $past(dest_id_i[15:8])})
    else $error("legacy destination not narrowed");

  chk_wide_dest: assert property ( // RULE5
    dest_valid_i && active_cfg_o.ext_en && !latch_table_ptr_i
    |=> dest_id_o == $past(dest_id_i))
    else $error("wide destination altered");

  chk_queue_rsvd: assert property ( // RULE12
    reg_bus_i.rd && !page_req_capable_i |=> reg_rdata_o[18:5] == 14'h0
    || hit($past(reg_bus_i), `OFF_TABLE_BASE))
    else $error("queue pointer visible without capability");

  chk_tail_adv: assert property ( // RULE11
    accept && $stable(queue_size_field_i)
    |=> write_offset_o[4:0] == 5'h0
    && (tail == (($past(tail) + 14'h1)
    & queue_index_mask($past(queue_size_field_i)))))
    else $error("tail did not advance by one entry");

  chk_full_block: assert property ( // RULE15
    queue_full_o |-> !page_req_ready_o ##1 (tail == $past(tail) || $past(wr_tail)))
    else $error("entry taken while queue full");

  chk_pending_set: assert property ( // RULE14
    accept |=> pending_page_req_flag_o [*1] ##0 (pending_page_req_flag_o))
    else $error("pending flag not set on entry");

  chk_reset_zero: assert property ( // RULE16
    $past(sys_rst_i) |-> stored == '0 && head == 14'h0 && tail == 14'h0
    && !pending_page_req_flag_o)
    else $error("fields not zero after reset");

  chk_latch_refused: assert property ( // RULE9
    latch_table_ptr_i && !intr_remap_capable_i
    |=> $stable(active_cfg_o) && $stable(table_entries_o))
    else $error("latch taken without remap capability");

  chk_table_drop: assert property ( // RULE9
    wr_table && !intr_remap_capable_i |=> $stable(stored))
    else $error("table base stored without capability");

  chk_base_high_zero: assert property ( // RULE2
    reg_bus_i.rd && hit(reg_bus_i, `OFF_TABLE_BASE)
    |=> (reg_rdata_o[63:12] & ~haw_mask()) == 52'h0)
    else $error("base bits above host width visible");

  chk_size_readback: assert property ( // RULE8
    reg_bus_i.rd && hit(reg_bus_i, `OFF_TABLE_BASE) && intr_remap_capable_i
    |=> reg_rdata_o[3:0] == $past(stored.size))
    else $error("size field readback wrong");

  chk_head_drop: assert property ( // RULE12
    wr_head && !page_req_capable_i |=> $stable(head))
    else $error("head stored without capability");

  chk_tail_drop: assert property ( // RULE12
    wr_tail && !page_req_capable_i |=> $stable(tail))
    else $error("tail stored without capability");

  chk_ready_refused: assert property ( // RULE12
    !page_req_capable_i |-> !page_req_ready_o)
    else $error("entry offered without capability");

  chk_ptr_rsvd_bits: assert property ( // RULE16
    reg_bus_i.rd && (hit(reg_bus_i, `OFF_QUEUE_HEAD) || hit(reg_bus_i, `OFF_QUEUE_TAIL))
    |=> reg_rdata_o[63:19] == 45'h0 && reg_rdata_o[4:0] == 5'h0)
    else $error("queue pointer reserved bits set");

  // a stale word left on the read port would be taken by a later poll
  chk_rdata_idle: assert property ( // RULE16
    !reg_bus_i.rd |=> reg_rdata_o == 64'h0)
    else $error("read data outside its cycle");

  // a software tail write lands modulo the queue size, like any advance
  chk_tail_sw_write: assert property ( // RULE15
    wr_tail && page_req_capable_i
    |=> tail == ($past(reg_bus_i.wdata[18:5]) & queue_index_mask($past(queue_size_field_i))))
    else $error("tail write not wrapped to queue size");

  chk_tail_idle: assert property ( // RULE11
    !accept && !wr_tail |=> $stable(tail))
    else $error("tail moved without an entry");

  chk_pending_hold: assert property ( // RULE14
    pending_page_req_flag_o && !pending_clear_i |=> pending_page_req_flag_o)
    else $error("pending flag dropped without clear");

  chk_pending_clear: assert property ( // RULE14
    pending_clear_i && !accept |=> !pending_page_req_flag_o)
    else $error("pending flag not cleared");

  chk_dest_valid: assert property ( // RULE5
    dest_valid_o == $past(dest_valid_i))
    else $error("destination valid not one cycle late");

  cov_latch: cover property (
    wr_table && intr_remap_capable_i ##[1:4] latch_table_ptr_i);
  cov_full: cover property (accept ##1 queue_full_o);
  cov_wrap: cover property (accept ##1 tail == 14'h0);
  cov_wide: cover property (active_cfg_o.ext_en && dest_valid_i);
  cov_pend_race: cover property (accept && pending_clear_i);

endmodule

// >>> remap_ptr_regs_tb_top.sv
/*
  self-checking testbench for the remap table and page queue pointer registers.
  assumes: remap_pkg and remap_regs.svh compiled ahead; single clock, sync reset.
*/
`timescale 1ns/10ps
`include "remap_regs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end

module remap_ptr_regs_tb_top;
  import remap_pkg::*;
  logic clock, sys_rst, latch, dest_valid, page_valid, pend_clr, cap_ir, cap_ext, cap_pr;
  logic [2:0] qsize;
  logic [31:0] dest_id;
  reg_bus_s bus;
  logic [63:0] rdata, rd_val;
  table_cfg_s active_cfg;
  logic [16:0] entries;
  logic dest_valid_o, ready, full, pending;
  logic [31:0] dest_o;
  logic [18:0] woff;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;

  remap_ptr_regs #(.HOST_ADDR_WIDTH(48)) dut (
    .clock_i(clock), .sys_rst_i(sys_rst), .reg_bus_i(bus), .reg_rdata_o(rdata),
    .intr_remap_capable_i(cap_ir), .ext_dest_format_capable_i(cap_ext),
    .page_req_capable_i(cap_pr), .latch_table_ptr_i(latch), .queue_size_field_i(qsize),
    .dest_valid_i(dest_valid), .dest_id_i(dest_id), .page_req_valid_i(page_valid),
    .pending_clear_i(pend_clr), .active_cfg_o(active_cfg), .table_entries_o(entries),
    .dest_valid_o(dest_valid_o), .dest_id_o(dest_o), .page_req_ready_o(ready),
    .queue_full_o(full), .write_offset_o(woff), .pending_page_req_flag_o(pending));

  // ************************************************************
  // clock, reset, timeout
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // whole run is under a hundred cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  // ************************************************************
  // bus and stimulus tasks
  // ************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [63:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  // read data only stands in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [7:0] a, output logic [63:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 64'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 d = rdata;
  endtask

  // write then read back with no gap, as the bus allows
  task automatic wr_rd_reg(input logic [7:0] a, input logic [63:0] d, output logic [63:0] q);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '{addr: a, wdata: 64'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 q = rdata;
  endtask

  task automatic push(input int n);
    @(posedge clock);
    page_valid <= 1'b1;
    repeat (n) @(posedge clock);
    page_valid <= 1'b0;
    #1;
  endtask

  task automatic pulse_latch();
    @(posedge clock);
    latch <= 1'b1;
    @(posedge clock);
    latch <= 1'b0;
    #1;
  endtask

  task automatic send_dest(input logic [31:0] id, input logic [31:0] exp);
    @(posedge clock);
    dest_valid <= 1'b1;
    dest_id <= id;
    @(posedge clock);
    dest_valid <= 1'b0;
    #1;
    `CHK(dest_valid_o, 1'b1)
    `CHK(dest_o, exp)
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset();
    rd_reg(`OFF_TABLE_BASE, rd_val);
    `CHK(rd_val, 64'h0)
    rd_reg(`OFF_QUEUE_HEAD, rd_val);
    `CHK(rd_val, 64'h0)
    rd_reg(`OFF_QUEUE_TAIL, rd_val);
    `CHK(rd_val, 64'h0)
    rd_reg(8'hd0, rd_val);
    `CHK(rd_val, 64'h0)
    `CHK(entries, 17'd2)
  endtask

  task automatic test_table();
    // base field aligned by position, remapping not active, size 11
    wr_rd_reg(`OFF_TABLE_BASE, 64'hffff_ffff_ffff_ffff & ~64'h4, rd_val);
    `CHK(rd_val, 64'h0000_ffff_ffff_f80b)
    `CHK(active_cfg, 57'h0)
    pulse_latch();
    `CHK(active_cfg, {52'h0000fffffffff, 1'b1, 4'hb})
    `CHK(entries, 17'd4096)
    send_dest(32'h1234_5678, 32'h1234_5678);
    wr_reg(`OFF_TABLE_BASE, 64'h0000_0000_0abc_d00f);
    pulse_latch();
    `CHK(entries, 17'd65536)
    send_dest(32'h1234_5678, 32'h0000_0056);
  endtask

  task automatic test_caps();
    @(posedge clock) cap_ext <= 1'b0;
    wr_reg(`OFF_TABLE_BASE, 64'h0000_0000_0000_0801);
    rd_reg(`OFF_TABLE_BASE, rd_val);
    `CHK(rd_val, 64'h1)
    @(posedge clock) cap_ir <= 1'b0;
    wr_reg(`OFF_TABLE_BASE, 64'h0000_0000_5555_5005);
    rd_reg(`OFF_TABLE_BASE, rd_val);
    `CHK(rd_val, 64'h0)
    pulse_latch();
    `CHK(active_cfg, {52'h0abcd, 1'b0, 4'hf})
    `CHK(entries, 17'd65536)
    @(posedge clock) cap_ir <= 1'b1;
    rd_reg(`OFF_TABLE_BASE, rd_val);
    `CHK(rd_val, 64'h1)
    @(posedge clock) cap_pr <= 1'b0;
    wr_reg(`OFF_QUEUE_HEAD, 64'h40);
    wr_reg(`OFF_QUEUE_TAIL, 64'h60);
    rd_reg(`OFF_QUEUE_HEAD, rd_val);
    `CHK(rd_val, 64'h0)
    `CHK(ready, 1'b0)
    @(posedge clock) cap_pr <= 1'b1;
    rd_reg(`OFF_QUEUE_HEAD, rd_val);
    `CHK(rd_val, 64'h0)
    rd_reg(`OFF_QUEUE_TAIL, rd_val);
    `CHK(rd_val, 64'h0)
  endtask

  task automatic test_queue();
    wr_reg(`OFF_QUEUE_HEAD, 64'hffff_ffff_fff8_0060); // head 3, reserved bits set
    rd_reg(`OFF_QUEUE_HEAD, rd_val);
    `CHK(rd_val, 64'h60)
    push(5);
    `CHK(woff, 19'h40)
    `CHK(full, 1'b1)
    `CHK(ready, 1'b0)
    `CHK(pending, 1'b1)
    @(posedge clock);
    pend_clr <= 1'b1;
    @(posedge clock);
    pend_clr <= 1'b0;
    #1 `CHK(pending, 1'b0)
    wr_reg(`OFF_QUEUE_TAIL, 64'hfe0); // tail 127, last slot of 128
    wr_reg(`OFF_QUEUE_HEAD, 64'ha0);
    push(3);
    rd_reg(`OFF_QUEUE_TAIL, rd_val);
    `CHK(rd_val, 64'h40)
    `CHK(full, 1'b0)
    @(posedge clock) qsize <= 3'd1;
    wr_reg(`OFF_QUEUE_TAIL, 64'hfe0);
    push(1);
    `CHK(woff, 19'h1000)
    // clear and a new entry in one cycle: the entry must win
    @(posedge clock);
    pend_clr <= 1'b1;
    page_valid <= 1'b1;
    @(posedge clock);
    pend_clr <= 1'b0;
    page_valid <= 1'b0;
    #1 `CHK(pending, 1'b1)
    `CHK(woff, 19'h1020)
  endtask

  // ************************************************************
  // main sequence and verdict
  // ************************************************************
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    bus = '0;
    latch = 1'b0;
    dest_valid = 1'b0;
    dest_id = 32'h0;
    page_valid = 1'b0;
    pend_clr = 1'b0;
    cap_ir = 1'b1;
    cap_ext = 1'b1;
    cap_pr = 1'b1;
    qsize = 3'd0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    test_reset();
    test_table();
    test_caps();
    test_queue();
    stop_test();
  end
endmodule
